/* shared/itd_pkg.sv */
// Package: constants and carriers for the instruction timing and dual pointer unit
package itd_pkg;
    // Special function register addresses
    localparam logic [7:0] SFR_POINTER0_LOW  = 8'h82;
    localparam logic [7:0] SFR_POINTER0_HIGH = 8'h83;
    localparam logic [7:0] SFR_POINTER1_LOW  = 8'h84;
    localparam logic [7:0] SFR_POINTER1_HIGH = 8'h85;
    localparam logic [7:0] SFR_POINTER_CTRL  = 8'h86;
    localparam logic [7:0] SFR_STATUS_WORD   = 8'hD0;
    localparam logic [7:0] SFR_BASE          = 8'h80;
    // Pointer control bit positions
    localparam int BIT_SELECT      = 0;
    localparam int BIT_STACK_EXT   = 1;
    localparam int BIT_EXT_MEM_EN  = 2;
    localparam int BIT_AUTO_STEP   = 4;
    localparam int BIT_AUTO_TOGGLE = 5;
    localparam int BIT_STEP_DOWN0  = 6;
    localparam int BIT_STEP_DOWN1  = 7;
    // Status word bank select bits
    localparam int BIT_BANK_LOW  = 3;
    localparam int BIT_BANK_HIGH = 4;
    // Reset values
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    // Execution cycle counts and absolute branch page mask
    localparam logic [1:0] EXEC_SHORT = 2'h1;
    localparam logic [1:0] EXEC_LONG  = 2'h3;
    localparam logic [10:0] PAGE_MASK = 11'h7FF;

    // Instruction classes that the decoder resolves
    typedef enum logic [3:0] {
        CLS_SIMPLE, CLS_CODE_MOVE, CLS_EXT_PTR_MOVE, CLS_BRANCH, CLS_COND_JUMP,
        CLS_BIT_CLEAR_JUMP, CLS_COMPARE_JUMP, CLS_DEC_JUMP, CLS_PTR_INC, CLS_ABS_BRANCH, CLS_LONG_BRANCH
    } itd_class_type;

    // Decoded instruction summary
    typedef struct packed {
        itd_class_type cls;
        logic [1:0]    length;
        logic          uses_pointer;
        logic          uses_bank_reg;
        logic          uses_indirect;
        logic [2:0]    reg_index;
    } itd_decode_type;

    // Pointer unit state
    typedef struct packed {
        logic [15:0] first;
        logic [15:0] second;
        logic [7:0]  control;
    } itd_pointers_type;
endpackage

/* core/itd_core.sv */
// Instruction timing decoder with dual pointer unit
`timescale 1ns/1ps
module itd_core
(
    // Clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_CE,
    // Instruction issue
    input  wire logic        I_ISSUE,
    input  wire logic [7:0]  I_OPCODE,
    input  wire logic [7:0]  I_OPERAND1,
    input  wire logic [7:0]  I_OPERAND2,
    input  wire logic [15:0] I_PC,
    input  wire logic [7:0]  I_ACC,
    input  wire logic [7:0]  I_STATUS_WORD,
    input  wire logic        I_CARRY,
    input  wire logic        I_BIT_VALUE,
    input  wire logic [7:0]  I_OPERAND_VALUE,
    input  wire logic [7:0]  I_INDIRECT_VALUE,
    // Special function register port
    input  wire logic        I_SFR_WR,
    input  wire logic [7:0]  I_SFR_ADDR,
    input  wire logic [7:0]  I_SFR_WDATA,
    output logic      [7:0]  O_SFR_RDATA,
    output logic             O_SFR_HIT,
    // Timing and addressing results
    output logic             O_BUSY,
    output logic      [2:0]  O_TOTAL_CYCLES,
    output logic      [1:0]  O_EXEC_CYCLES,
    output logic             O_BRANCH_TAKEN,
    output logic      [15:0] O_BRANCH_TARGET,
    output logic      [15:0] O_POINTER_ADDR,
    output logic      [7:0]  O_REG_ADDR,
    output logic      [7:0]  O_INDIRECT_ADDR,
    output logic             O_DIRECT_IS_SFR,
    output logic             O_CLEAR_BIT,
    output logic      [7:0]  O_DEC_RESULT,
    output logic      [7:0]  O_NIBBLE_ACC,
    output logic      [7:0]  O_NIBBLE_MEM,
    output logic      [15:0] O_ACTIVE_POINTER,
    output logic             O_EXT_MEM_EN,
    output logic             O_STACK_EXT_SEL
);
    itd_pkg::itd_decode_type   dec;
    itd_pkg::itd_pointers_type ptr;
    itd_pkg::itd_pointers_type next_ptr;
    logic [2:0]  busy_count;
    logic [2:0]  next_busy_count;
    logic [15:0] next_pc;
    logic [15:0] rel_target;
    logic        taken;
    logic [1:0]  exec;
    logic [15:0] target;
    logic [7:0]  dec_value;
    logic        select;
    logic [15:0] active;
    logic [15:0] stepped;
    logic [2:0]  next_total;
    logic [1:0]  next_exec;
    logic        issue;

    assign issue  = I_CE && I_ISSUE && (busy_count == 3'h0);
    assign select = ptr.control[itd_pkg::BIT_SELECT];
    assign active = select ? ptr.second : ptr.first;

    // Opcode classification
    always_comb
    begin
        dec = '{cls: itd_pkg::CLS_SIMPLE, length: 2'h1, uses_pointer: 1'b0,
                uses_bank_reg: 1'b0, uses_indirect: 1'b0, reg_index: I_OPCODE[2:0]};
        dec.uses_bank_reg = I_OPCODE[3];
        dec.uses_indirect = (I_OPCODE[3:1] == 3'h3);
        case (I_OPCODE)
            8'hA3: dec.cls = itd_pkg::CLS_PTR_INC;
            8'h93: begin dec.cls = itd_pkg::CLS_CODE_MOVE; dec.uses_pointer = 1'b1; end
            8'h83: dec.cls = itd_pkg::CLS_CODE_MOVE;
            8'hE0, 8'hF0: begin dec.cls = itd_pkg::CLS_EXT_PTR_MOVE; dec.uses_pointer = 1'b1; end
            8'h02, 8'h12: begin dec.cls = itd_pkg::CLS_LONG_BRANCH; dec.length = 2'h3; end
            8'h22, 8'h32, 8'h73: dec.cls = itd_pkg::CLS_BRANCH;
            8'h80: begin dec.cls = itd_pkg::CLS_BRANCH; dec.length = 2'h2; end
            8'h40, 8'h50, 8'h60, 8'h70: begin dec.cls = itd_pkg::CLS_COND_JUMP; dec.length = 2'h2; end
            8'h20, 8'h30: begin dec.cls = itd_pkg::CLS_COND_JUMP; dec.length = 2'h3; end
            8'h10: begin dec.cls = itd_pkg::CLS_BIT_CLEAR_JUMP; dec.length = 2'h3; end
            8'h75, 8'h85, 8'h90: dec.length = 2'h3;
            8'hA0, 8'hB0, 8'hC0, 8'hD0: dec.length = 2'h2;
            8'h43, 8'h53, 8'h63: dec.length = 2'h3;
            8'hD5: begin dec.cls = itd_pkg::CLS_DEC_JUMP; dec.length = 2'h3; end
            default:
            begin
                if (I_OPCODE[3:0] == 4'h1)
                begin
                    dec.cls    = itd_pkg::CLS_ABS_BRANCH;
                    dec.length = 2'h2;
                end
                else if (I_OPCODE[7:4] == 4'hB && I_OPCODE[3:2] != 2'h0)
                begin
                    dec.cls    = itd_pkg::CLS_COMPARE_JUMP;
                    dec.length = 2'h3;
                end
                else if (I_OPCODE[7:3] == 5'h1B)
                begin
                    dec.cls    = itd_pkg::CLS_DEC_JUMP;
                    dec.length = 2'h2;
                end
                // operand byte forms
                // External moves via R0/R1, multiply and divide stay one byte
                else if ((I_OPCODE[3:0] == 4'h2 && I_OPCODE[7:5] != 3'h7) || I_OPCODE[3:0] == 4'h5 ||
                         (I_OPCODE[3:0] == 4'h4 && I_OPCODE[7:4] > 4'h1 && I_OPCODE[7:4] < 4'hA &&
                          I_OPCODE[7:4] != 4'h8) ||
                         (I_OPCODE[3:1] > 3'h2 && (I_OPCODE[7:4] == 4'h7 || I_OPCODE[7:4] == 4'h8 ||
                          I_OPCODE[7:4] == 4'hA)))
                    dec.length = 2'h2;
            end
        endcase
    end

    // Branch resolution and timing
    always_comb
    begin
        next_pc    = I_PC + {14'h0000, dec.length};
        rel_target = next_pc + {{8{I_OPERAND2[7]}}, I_OPERAND2};
        dec_value  = I_OPERAND_VALUE - 8'h01;
        taken      = 1'b0;
        target     = next_pc;
        case (dec.cls)
            itd_pkg::CLS_BRANCH, itd_pkg::CLS_CODE_MOVE:
            begin
                taken  = (dec.cls == itd_pkg::CLS_BRANCH);
                target = (I_OPCODE == 8'h73) ? active + {8'h00, I_ACC}
                       : next_pc + {{8{I_OPERAND1[7]}}, I_OPERAND1};
            end
            itd_pkg::CLS_ABS_BRANCH:
            begin
                taken  = 1'b1;
                target = {next_pc[15:11], I_OPCODE[7:5] & itd_pkg::PAGE_MASK[10:8], I_OPERAND1};
            end
            itd_pkg::CLS_LONG_BRANCH:
            begin
                taken  = 1'b1;
                target = {I_OPERAND1, I_OPERAND2};
            end
            itd_pkg::CLS_COND_JUMP:
            begin
                case (I_OPCODE)
                    8'h40: taken = I_CARRY;
                    8'h50: taken = !I_CARRY;
                    8'h60: taken = (I_ACC == 8'h00);
                    8'h70: taken = (I_ACC != 8'h00);
                    8'h20: taken = I_BIT_VALUE;
                    8'h30: taken = !I_BIT_VALUE;
                    default: taken = 1'b0;
                endcase
                target = (dec.length == 2'h2) ? next_pc + {{8{I_OPERAND1[7]}}, I_OPERAND1} : rel_target;
            end
            itd_pkg::CLS_BIT_CLEAR_JUMP:
            begin
                taken  = I_BIT_VALUE;
                target = rel_target;
            end
            itd_pkg::CLS_COMPARE_JUMP:
            begin
                taken  = (I_OPCODE[3:0] == 4'h5) ? (I_ACC != I_OPERAND_VALUE)
                       : (I_OPCODE[3:0] == 4'h4) ? (I_ACC != I_OPERAND1)
                       : (I_OPERAND_VALUE != I_OPERAND1);
                target = rel_target;
            end
            itd_pkg::CLS_DEC_JUMP:
            begin
                taken  = (dec_value != 8'h00);
                target = (dec.length == 2'h2) ? next_pc + {{8{I_OPERAND1[7]}}, I_OPERAND1} : rel_target;
            end
            default: taken = 1'b0;
        endcase
        if (dec.cls == itd_pkg::CLS_CODE_MOVE || taken)
            next_exec = itd_pkg::EXEC_LONG;
        else
            next_exec = itd_pkg::EXEC_SHORT;
        next_total = {1'b0, dec.length} + {1'b0, next_exec} - 3'h1;
    end

    // Pointer step, direction per pointer
    always_comb
    begin
        if (ptr.control[select ? itd_pkg::BIT_STEP_DOWN1 : itd_pkg::BIT_STEP_DOWN0])
            stepped = active - 16'h0001;
        else
            stepped = active + 16'h0001;
    end

    // Pointer unit next state
    always_comb
    begin
        next_ptr = ptr;
        if (I_CE)
        begin
            if (I_SFR_WR)
            begin
                case (I_SFR_ADDR)
                    itd_pkg::SFR_POINTER0_LOW:  next_ptr.first[7:0]   = I_SFR_WDATA;
                    itd_pkg::SFR_POINTER0_HIGH: next_ptr.first[15:8]  = I_SFR_WDATA;
                    itd_pkg::SFR_POINTER1_LOW:  next_ptr.second[7:0]  = I_SFR_WDATA;
                    itd_pkg::SFR_POINTER1_HIGH: next_ptr.second[15:8] = I_SFR_WDATA;
                    itd_pkg::SFR_POINTER_CTRL:  next_ptr.control      = I_SFR_WDATA & 8'hF7;
                    default: next_ptr = ptr;
                endcase
            end
            if (issue && (dec.cls == itd_pkg::CLS_PTR_INC ||
                (dec.uses_pointer && ptr.control[itd_pkg::BIT_AUTO_STEP])))
            begin
                if (select)
                    next_ptr.second = stepped;
                else
                    next_ptr.first = stepped;
            end
            if (issue && dec.uses_pointer && ptr.control[itd_pkg::BIT_AUTO_TOGGLE])
                next_ptr.control[itd_pkg::BIT_SELECT] = !select;
        end
    end

    // Busy count covers remaining cycles of the issued instruction
    always_comb
    begin
        next_busy_count = busy_count;
        if (I_CE)
        begin
            // Three bits: a five-cycle branch leaves four busy cycles
            if (issue)
                next_busy_count = next_total - 3'h1;
            else if (busy_count != 3'h0)
                next_busy_count = busy_count - 3'h1;
        end
    end

    // old pointer used, update registered after
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            ptr        <= '{first: itd_pkg::POINTER_RESET, second: itd_pkg::POINTER_RESET,
                            control: itd_pkg::CTRL_RESET};
            busy_count <= 3'h0;
        end
        else
        begin
            ptr        <= next_ptr;
            busy_count <= next_busy_count;
        end
    end

    // Registered decode results
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            O_TOTAL_CYCLES  <= 3'h0;
            O_EXEC_CYCLES   <= 2'h0;
            O_BRANCH_TAKEN  <= 1'b0;
            O_BRANCH_TARGET <= 16'h0000;
            O_POINTER_ADDR  <= 16'h0000;
            O_REG_ADDR      <= 8'h00;
            O_INDIRECT_ADDR <= 8'h00;
            O_DIRECT_IS_SFR <= 1'b0;
            O_CLEAR_BIT     <= 1'b0;
            O_DEC_RESULT    <= 8'h00;
            O_NIBBLE_ACC    <= 8'h00;
            O_NIBBLE_MEM    <= 8'h00;
        end
        else if (issue)
        begin
            O_TOTAL_CYCLES  <= next_total;
            O_EXEC_CYCLES   <= next_exec;
            O_BRANCH_TAKEN  <= taken;
            O_BRANCH_TARGET <= target;
            O_POINTER_ADDR  <= (I_OPCODE == 8'h83) ? next_pc + {8'h00, I_ACC}
                             : active + ((dec.cls == itd_pkg::CLS_CODE_MOVE) ? {8'h00, I_ACC} : 16'h0000);
            O_REG_ADDR      <= (dec.uses_bank_reg || dec.uses_indirect) ?
                               {3'h0, I_STATUS_WORD[itd_pkg::BIT_BANK_HIGH], I_STATUS_WORD[itd_pkg::BIT_BANK_LOW],
                                dec.uses_indirect ? {2'h0, I_OPCODE[0]} : dec.reg_index} : 8'h00;
            O_INDIRECT_ADDR <= I_INDIRECT_VALUE;
            O_DIRECT_IS_SFR <= (I_OPERAND1 >= itd_pkg::SFR_BASE);
            O_CLEAR_BIT     <= (dec.cls == itd_pkg::CLS_BIT_CLEAR_JUMP) && I_BIT_VALUE;
            O_DEC_RESULT    <= dec_value;
            O_NIBBLE_ACC    <= {I_ACC[7:4], I_OPERAND_VALUE[3:0]};
            O_NIBBLE_MEM    <= {I_OPERAND_VALUE[7:4], I_ACC[3:0]};
        end
    end

    // Register read mux
    always_comb
    begin
        O_SFR_HIT = 1'b1;
        case (I_SFR_ADDR)
            itd_pkg::SFR_POINTER0_LOW:  O_SFR_RDATA = ptr.first[7:0];
            itd_pkg::SFR_POINTER0_HIGH: O_SFR_RDATA = ptr.first[15:8];
            itd_pkg::SFR_POINTER1_LOW:  O_SFR_RDATA = ptr.second[7:0];
            itd_pkg::SFR_POINTER1_HIGH: O_SFR_RDATA = ptr.second[15:8];
            itd_pkg::SFR_POINTER_CTRL:  O_SFR_RDATA = ptr.control;
            default:
            begin
                O_SFR_RDATA = 8'h00;
                O_SFR_HIT   = 1'b0;
            end
        endcase
    end

    assign O_BUSY           = (busy_count != 3'h0);
    assign O_ACTIVE_POINTER = active;
    assign O_EXT_MEM_EN     = ptr.control[itd_pkg::BIT_EXT_MEM_EN];
    assign O_STACK_EXT_SEL  = ptr.control[itd_pkg::BIT_STACK_EXT];
endmodule

/* verification/itd_core_properties.sv */
// Concurrent checks on the timing decoder and dual pointer ports
`timescale 1ns/1ps
module itd_core_properties
(
    // Clock and reset
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic        I_CE,
    // Issue and register port
    input wire logic        I_ISSUE,
    input wire logic [7:0]  I_OPCODE,
    input wire logic [7:0]  I_OPERAND1,
    input wire logic [7:0]  I_OPERAND2,
    input wire logic [15:0] I_PC,
    input wire logic        I_BIT_VALUE,
    input wire logic        I_SFR_WR,
    input wire logic [7:0]  I_SFR_ADDR,
    // Observed results
    input wire logic        O_BUSY,
    input wire logic [2:0]  O_TOTAL_CYCLES,
    input wire logic [1:0]  O_EXEC_CYCLES,
    input wire logic        O_BRANCH_TAKEN,
    input wire logic [15:0] O_BRANCH_TARGET,
    input wire logic [15:0] O_POINTER_ADDR,
    input wire logic        O_DIRECT_IS_SFR,
    input wire logic        O_CLEAR_BIT,
    input wire logic        O_SFR_HIT,
    input wire logic [15:0] O_ACTIVE_POINTER
);
    logic        accepted;
    logic [15:0] rel_dest;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RST);
    // Offset counts from the byte after a two-byte jump
    always_comb
    begin
        accepted = I_CE && I_ISSUE && !O_BUSY;
        rel_dest = I_PC + 16'h0002 + {{8{I_OPERAND1[7]}}, I_OPERAND1};
    end
    sequence long_issue;
        accepted ##1 (O_TOTAL_CYCLES == 3'h4);
    endsequence
    sequence busy_three;
        O_BUSY [*3] ##1 !O_BUSY;
    endsequence
    sequence busy_four;
        O_BUSY [*4] ##1 !O_BUSY;
    endsequence
    a_busy_span: assert property (long_issue |-> busy_three)
        else $error("busy span differs from total cycles");
    a_busy_long: assert property (accepted ##1 (O_TOTAL_CYCLES == 3'h5) |-> busy_four)
        else $error("long busy span differs from total cycles");
    a_short_jump: assert property (accepted && I_OPCODE == 8'h80 |=>
        O_BRANCH_TAKEN && O_TOTAL_CYCLES == 3'h4 && O_EXEC_CYCLES == 2'h3) else $error("short jump timing wrong");
    a_rel_target: assert property (accepted && I_OPCODE == 8'h80 |=> O_BRANCH_TARGET == $past(rel_dest))
        else $error("relative target wrong");
    a_add_single: assert property (accepted && I_OPCODE == 8'h28 |=>
        !O_BUSY && O_TOTAL_CYCLES == 3'h1 && O_EXEC_CYCLES == 2'h1) else $error("add not single cycle");
    a_long_target: assert property (accepted && (I_OPCODE == 8'h02 || I_OPCODE == 8'h12) |=>
        O_BRANCH_TARGET == {$past(I_OPERAND1), $past(I_OPERAND2)} && O_TOTAL_CYCLES == 3'h5)
        else $error("long target wrong");
    a_old_pointer: assert property (accepted && I_OPCODE == 8'hE0 |=>
        O_POINTER_ADDR == $past(O_ACTIVE_POINTER)) else $error("move did not use old pointer");
    a_step_pointer: assert property (accepted && I_OPCODE == 8'hA3 && !I_SFR_WR |=>
        O_ACTIVE_POINTER == $past(O_ACTIVE_POINTER) + 16'h0001 || O_ACTIVE_POINTER == $past(O_ACTIVE_POINTER) - 16'h0001)
        else $error("pointer step not by one");
    a_bit_clear: assert property (accepted && I_OPCODE == 8'h10 && I_BIT_VALUE |=> O_CLEAR_BIT && O_BRANCH_TAKEN)
        else $error("set bit not cleared and taken");
    a_direct_space: assert property (accepted |=> O_DIRECT_IS_SFR == ($past(I_OPERAND1) >= 8'h80))
        else $error("direct space decode wrong");
    a_refuse_busy: assert property (O_BUSY |=> $stable(O_TOTAL_CYCLES) && $stable(O_BRANCH_TARGET))
        else $error("issue taken while busy");
    a_sfr_decode: assert property (O_SFR_HIT == (I_SFR_ADDR >= 8'h82 && I_SFR_ADDR <= 8'h86))
        else $error("register hit decode wrong");
endmodule

bind itd_core itd_core_properties u_props
(
    .I_CLK, .I_RST, .I_CE, .I_ISSUE, .I_OPCODE, .I_OPERAND1, .I_OPERAND2, .I_PC, .I_BIT_VALUE, .I_SFR_WR, .I_SFR_ADDR,
    .O_BUSY, .O_TOTAL_CYCLES, .O_EXEC_CYCLES, .O_BRANCH_TAKEN, .O_BRANCH_TARGET, .O_POINTER_ADDR, .O_DIRECT_IS_SFR,
    .O_CLEAR_BIT, .O_SFR_HIT, .O_ACTIVE_POINTER
);

/* verification/cpu_instr_timing_dual_pointer_tb.sv */
// Self-checking bench for the timing decoder and dual pointer unit
`timescale 1ns/1ps
module cpu_instr_timing_dual_pointer_tb;
    logic        I_CLK = 1'b0;
    logic        I_RST = 1'b1;
    logic        I_CE = 1'b1;
    logic        I_ISSUE = 1'b0;
    logic        I_CARRY = 1'b0;
    logic        I_BIT_VALUE = 1'b0;
    logic        I_SFR_WR = 1'b0;
    logic [7:0]  I_OPCODE = 8'h00;
    logic [7:0]  I_OPERAND1 = 8'h00;
    logic [7:0]  I_OPERAND2 = 8'h00;
    logic [15:0] I_PC = 16'h0000;
    logic [7:0]  I_ACC = 8'h00;
    logic [7:0]  I_STATUS_WORD = 8'h00;
    logic [7:0]  I_OPERAND_VALUE = 8'h00;
    logic [7:0]  I_INDIRECT_VALUE = 8'h00;
    logic [7:0]  I_SFR_ADDR = 8'h00;
    logic [7:0]  I_SFR_WDATA = 8'h00;
    logic        O_SFR_HIT, O_BUSY, O_BRANCH_TAKEN, O_DIRECT_IS_SFR, O_CLEAR_BIT, O_EXT_MEM_EN, O_STACK_EXT_SEL;
    logic [1:0]  O_EXEC_CYCLES;
    logic [2:0]  O_TOTAL_CYCLES;
    logic [7:0]  O_SFR_RDATA, O_REG_ADDR, O_INDIRECT_ADDR, O_DEC_RESULT, O_NIBBLE_ACC, O_NIBBLE_MEM;
    logic [15:0] O_BRANCH_TARGET, O_POINTER_ADDR, O_ACTIVE_POINTER;
    int          n_fail = 0;
    int          n_tests = 0;

    itd_core dut
    (
        .I_CLK, .I_RST, .I_CE, .I_ISSUE, .I_OPCODE, .I_OPERAND1, .I_OPERAND2, .I_PC, .I_ACC, .I_STATUS_WORD,
        .I_CARRY, .I_BIT_VALUE, .I_OPERAND_VALUE, .I_INDIRECT_VALUE, .I_SFR_WR, .I_SFR_ADDR, .I_SFR_WDATA,
        .O_SFR_RDATA, .O_SFR_HIT, .O_BUSY, .O_TOTAL_CYCLES, .O_EXEC_CYCLES, .O_BRANCH_TAKEN, .O_BRANCH_TARGET,
        .O_POINTER_ADDR, .O_REG_ADDR, .O_INDIRECT_ADDR, .O_DIRECT_IS_SFR, .O_CLEAR_BIT, .O_DEC_RESULT,
        .O_NIBBLE_ACC, .O_NIBBLE_MEM, .O_ACTIVE_POINTER, .O_EXT_MEM_EN, .O_STACK_EXT_SEL
    );

    initial
    begin
        forever #25 I_CLK = ~I_CLK;
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Strobe drops and one edge passes, so writes never re-raise in one step
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        I_SFR_WR = 1'b1;
        I_SFR_ADDR = a;
        I_SFR_WDATA = d;
        @(posedge I_CLK);
        #2;
        I_SFR_WR = 1'b0;
        @(posedge I_CLK);
        #2;
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] d, input logic h);
        I_SFR_ADDR = a;
        #1;
        chk(O_SFR_HIT, h);
        if (h)
            chk(O_SFR_RDATA, d);
        @(posedge I_CLK);
        #2;
    endtask

    // Issue stays high; while busy a different opcode waits and must be refused
    task automatic run_case(input logic [7:0] op, o1, o2, v, input logic [15:0] pc, input logic [11:0] e);
        int k;
        k = 0;
        while (O_BUSY !== 1'b0 && k < 10)
        begin
            @(posedge I_CLK);
            #2;
            k++;
        end
        I_ISSUE = 1'b1;
        I_OPCODE = op;
        I_OPERAND1 = o1;
        I_OPERAND2 = o2;
        I_PC = pc;
        I_ACC = v;
        I_OPERAND_VALUE = {v[3:0], v[7:4]};
        I_BIT_VALUE = v[0];
        @(posedge I_CLK);
        #2;
        chk(O_TOTAL_CYCLES, e[10:8]);
        chk(O_EXEC_CYCLES, e[5:4]);
        chk(O_BRANCH_TAKEN, e[0]);
        if (O_BUSY === 1'b1)
            I_OPCODE = 8'h00;
    endtask

    task automatic load_ptrs(input logic [7:0] p0l, p0h, p1l, p1h);
        sfr_wr(8'h82, p0l);
        sfr_wr(8'h83, p0h);
        sfr_wr(8'h84, p1l);
        sfr_wr(8'h85, p1h);
    endtask

    task automatic rst_chk();
        for (int i = 0; i < 5; i++)
            sfr_rd(8'h82 + i[7:0], 8'h00, 1'b1);
        sfr_rd(8'h87, 8'h00, 1'b0);
        chk(O_ACTIVE_POINTER, 16'h0000);
        chk(O_BUSY, 1'b0);
    endtask

    initial
    begin
        repeat (5000) @(posedge I_CLK);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end

    initial
    begin
        repeat (10) @(posedge I_CLK);
        #2;
        I_RST = 1'b0;
        rst_chk();
        $display("test reset values done");
        load_ptrs(8'h34, 8'h12, 8'h78, 8'h56);
        sfr_rd(8'h83, 8'h12, 1'b1);
        sfr_rd(8'h84, 8'h78, 1'b1);
        chk(O_ACTIVE_POINTER, 16'h1234);
        sfr_wr(8'h86, 8'hFF);
        sfr_rd(8'h86, 8'hF7, 1'b1);
        chk(O_ACTIVE_POINTER, 16'h5678);
        chk({O_EXT_MEM_EN, O_STACK_EXT_SEL}, 2'h3);
        I_CE = 1'b0;
        sfr_wr(8'h84, 8'h00);
        I_CE = 1'b1;
        sfr_rd(8'h84, 8'h78, 1'b1);
        $display("test register access done");
        load_ptrs(8'h00, 8'h10, 8'h00, 8'h20);
        // Auto step, auto toggle, second pointer steps down
        sfr_wr(8'h86, 8'hB0);
        run_case(8'hE0, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        chk(O_POINTER_ADDR, 16'h1000);
        chk(O_ACTIVE_POINTER, 16'h2000);
        run_case(8'hE0, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        chk(O_POINTER_ADDR, 16'h2000);
        chk(O_ACTIVE_POINTER, 16'h1001);
        run_case(8'h93, 8'h00, 8'h00, 8'h05, 16'h0000, 12'h330);
        chk(O_POINTER_ADDR, 16'h1006);
        chk(O_ACTIVE_POINTER, 16'h1FFF);
        run_case(8'hA3, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        I_ISSUE = 1'b0;
        chk(O_ACTIVE_POINTER, 16'h1FFE);
        sfr_rd(8'h85, 8'h1F, 1'b1);
        sfr_rd(8'h82, 8'h02, 1'b1);
        sfr_rd(8'h86, 8'hB1, 1'b1);
        sfr_wr(8'h86, 8'h00);
        run_case(8'hA3, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        chk(O_ACTIVE_POINTER, 16'h1003);
        run_case(8'hE0, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        chk(O_ACTIVE_POINTER, 16'h1003);
        $display("test dual pointer done");
        run_case(8'h28, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        run_case(8'h34, 8'h11, 8'h00, 8'h00, 16'h0000, 12'h210);
        run_case(8'h96, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        run_case(8'hA4, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        run_case(8'h83, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h330);
        run_case(8'hE2, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        run_case(8'h12, 8'h12, 8'h34, 8'h00, 16'h0000, 12'h531);
        chk(O_BRANCH_TARGET, 16'h1234);
        run_case(8'h22, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h331);
        run_case(8'h80, 8'hFE, 8'h00, 8'h00, 16'h0100, 12'h431);
        chk(O_BRANCH_TARGET, 16'h0100);
        run_case(8'h21, 8'h34, 8'h00, 8'h00, 16'h07FE, 12'h431);
        chk(O_BRANCH_TARGET, 16'h0934);
        run_case(8'h60, 8'h10, 8'h00, 8'h01, 16'h0200, 12'h210);
        run_case(8'h60, 8'h10, 8'h00, 8'h00, 16'h0200, 12'h431);
        chk(O_BRANCH_TARGET, 16'h0212);
        run_case(8'h40, 8'h10, 8'h00, 8'h00, 16'h0200, 12'h210);
        run_case(8'h50, 8'h10, 8'h00, 8'h00, 16'h0200, 12'h431);
        run_case(8'hB4, 8'h5A, 8'h08, 8'h5A, 16'h0300, 12'h310);
        run_case(8'hB4, 8'h5A, 8'h08, 8'h5B, 16'h0300, 12'h531);
        chk(O_BRANCH_TARGET, 16'h030B);
        run_case(8'hD8, 8'h04, 8'h00, 8'h10, 16'h0000, 12'h210);
        chk(O_DEC_RESULT, 8'h00);
        run_case(8'hD8, 8'h04, 8'h00, 8'h20, 16'h0000, 12'h431);
        chk(O_DEC_RESULT, 8'h01);
        run_case(8'h10, 8'h20, 8'h04, 8'h01, 16'h0000, 12'h531);
        chk(O_CLEAR_BIT, 1'b1);
        run_case(8'h10, 8'h20, 8'h04, 8'h00, 16'h0000, 12'h310);
        chk(O_CLEAR_BIT, 1'b0);
        $display("test instruction timing done");
        I_STATUS_WORD = 8'h18;
        run_case(8'h2D, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        chk(O_REG_ADDR, 8'h1D);
        I_STATUS_WORD = 8'h10;
        I_INDIRECT_VALUE = 8'h40;
        run_case(8'h27, 8'h00, 8'h00, 8'h00, 16'h0000, 12'h110);
        chk(O_REG_ADDR, 8'h11);
        chk(O_INDIRECT_ADDR, 8'h40);
        run_case(8'hD6, 8'h00, 8'h00, 8'hAB, 16'h0000, 12'h110);
        chk({O_NIBBLE_ACC, O_NIBBLE_MEM}, 16'hAABB);
        run_case(8'h25, 8'h7F, 8'h00, 8'h00, 16'h0000, 12'h210);
        chk(O_DIRECT_IS_SFR, 1'b0);
        run_case(8'h25, 8'h80, 8'h00, 8'h00, 16'h0000, 12'h210);
        chk(O_DIRECT_IS_SFR, 1'b1);
        I_ISSUE = 1'b0;
        $display("test addressing done");
        I_RST = 1'b1;
        repeat (2) @(posedge I_CLK);
        #2;
        I_RST = 1'b0;
        rst_chk();
        $display("test second reset done");
        summarize();
    end
endmodule
